//--- lsbr_regs.vh
// Constants for the lamp status, brightness and soft-start register bank
// Summary of operation
// RQ1 - Status one bit 0 shows channel one fault
// RQ2 - Status two bit 0 shows channel two fault
// RQ3 - Bit 1 latches fault entry, clears on read
// RQ4 - Bit 2 latches strike failure, clears on read
// RQ5 - Bit 3 latches after 64-cycle overvoltage, read-clears
// RQ6 - Bit 4 latches lamp-out, clears on read
// RQ7 - Bit 5 latches overcurrent, clears on read
// RQ8 - Status one bits 6/7 show supply monitors live
// RQ9 - Writes to status registers are ignored
// RQ10 - Status one cleared by supply/power events, channel-one off
// RQ11 - Status two cleared by supply/power events, channel-two off
// RQ12 - Status two bits 6/7 reserved, host ignores
// RQ13 - Bits 4:0 set lamp current, 35-100%
// RQ14 - Bit 5 disables channel one
// RQ15 - Bit 6 disables channel two
// RQ16 - Bit 7 blocks nonvolatile writes
// RQ17 - Four soft-start registers hold two duty codes
// RQ18 - Timeout select gives 32768/65536/98304 lamp cycles
// RQ19 - Duty codes give fixed duties; 7 repeats
// RQ20 - Event during clear-on-read keeps flag set
`ifndef LSBR_REGS_VH
`define LSBR_REGS_VH

// ****************************************
// Register addresses
// ****************************************
`define LSBR_ADDR_CH1_STATUS 8'hE0
`define LSBR_ADDR_CH2_STATUS 8'hE1
`define LSBR_ADDR_BRIGHTNESS 8'hE3
`define LSBR_ADDR_SS_1_4 8'hF0
`define LSBR_ADDR_SS_5_8 8'hF1
`define LSBR_ADDR_SS_9_12 8'hF2
`define LSBR_ADDR_SS_13_16 8'hF3

// ****************************************
// Reset values
// ****************************************
`define LSBR_RST_STATUS 8'h00
`define LSBR_RST_BRIGHTNESS 8'h00
`define LSBR_RST_SS_1_4 8'h21
`define LSBR_RST_SS_5_8 8'h43
`define LSBR_RST_SS_9_12 8'h65
`define LSBR_RST_SS_13_16 8'h77

// ****************************************
// Field positions
// ****************************************
`define LSBR_ST_FAULT_NOW 0
`define LSBR_ST_FAULT_SEEN 1
`define LSBR_ST_STRIKE 2
`define LSBR_ST_OVERVOLT 3
`define LSBR_ST_LAMP_OUT 4
`define LSBR_ST_OVERCUR 5
`define LSBR_ST_SUPPLY_LOW 6
`define LSBR_ST_SUPPLY_HIGH 7
`define LSBR_BR_CUR_MSB 4
`define LSBR_BR_CH1_OFF 5
`define LSBR_BR_CH2_OFF 6
`define LSBR_BR_NV_BLOCK 7
`define LSBR_SS_TMO_LO 3
`define LSBR_SS_TMO_HI 7
`define LSBR_SS_LO_MSB 2
`define LSBR_SS_HI_LSB 4
`define LSBR_SS_HI_MSB 6

// ****************************************
// Timing and code tables
// ****************************************
`define LSBR_OV_PERSIST 7'h40
`define LSBR_TMO_CODE_0 17'h08000
`define LSBR_TMO_CODE_1 17'h10000
`define LSBR_TMO_CODE_2 17'h18000
`define LSBR_DUTY_0 5'h00
`define LSBR_DUTY_1 5'h03
`define LSBR_DUTY_2 5'h06
`define LSBR_DUTY_3 5'h09
`define LSBR_DUTY_4 5'h0D
`define LSBR_DUTY_5 5'h10
`define LSBR_DUTY_6 5'h13
`define LSBR_DUTY_REPEAT 3'h7

`endif

//--- lsbr_chan_status.v
// One channel's fault status flags
`timescale 1ns/1ps
`include "lsbr_regs.vh"
module lsbr_chan_status #(
	parameter OV_CNT_W = 7
) (
	// Clock and reset
	input wire ref_clk_in,
	input wire srst_in,
	// Clearing
	input wire clear_in,
	input wire read_clear_in,
	// Fault detector inputs
	input wire fault_now_in,
	input wire fault_enter_in,
	input wire strike_fail_in,
	input wire overvoltage_in,
	input wire lamp_tick_in,
	input wire lamp_out_in,
	input wire overcurrent_in,
	// Flags, bit 0 live, bits 5:1 latched
	output wire [5:0] flags_out
);

reg [4:0] seen_q;
reg [4:0] seen_d;
reg [OV_CNT_W-1:0] ov_cnt_q;
reg [OV_CNT_W-1:0] ov_cnt_d;
wire ov_done;
wire [4:0] set_ev;

// ****************************************
// Overvoltage persistence counter
// ****************************************
assign ov_done = (ov_cnt_q >= `LSBR_OV_PERSIST); // RQ5

always @* begin
	ov_cnt_d = ov_cnt_q;
	if (clear_in || !overvoltage_in) begin
		ov_cnt_d = {OV_CNT_W{1'b0}};
	end else if (lamp_tick_in && !ov_done) begin
		ov_cnt_d = ov_cnt_q + 1'b1; // RQ5
	end
end

// ****************************************
// Latched flags
// ****************************************
assign set_ev = {overcurrent_in, lamp_out_in, ov_done, strike_fail_in, fault_enter_in};

always @* begin
	if (clear_in) begin
		seen_d = 5'h00;
	end else if (read_clear_in) begin
		seen_d = set_ev; // RQ3 RQ20
	end else begin
		seen_d = seen_q | set_ev; // RQ4 RQ6 RQ7
	end
end

always @(posedge ref_clk_in) begin
	if (srst_in) begin
		seen_q <= 5'h00;
		ov_cnt_q <= {OV_CNT_W{1'b0}};
	end else begin
		seen_q <= seen_d;
		ov_cnt_q <= ov_cnt_d;
	end
end

assign flags_out = {seen_q, fault_now_in}; // RQ1 RQ2

endmodule // lsbr_chan_status

//--- lsbr_top.v
// Lamp status, brightness and soft-start register bank
`timescale 1ns/1ps
`include "lsbr_regs.vh"
module lsbr_top (
	// Clock and reset
	input wire ref_clk_in,
	input wire srst_in,
	// Register access from the serial interface
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [7:0] reg_rdata_out,
	output reg reg_rvalid_out,
	// Channel one detectors
	input wire ch1_fault_now_in,
	input wire ch1_fault_enter_in,
	input wire ch1_strike_fail_in,
	input wire ch1_overvoltage_in,
	input wire ch1_lamp_out_in,
	input wire ch1_overcurrent_in,
	// Channel two detectors
	input wire ch2_fault_now_in,
	input wire ch2_fault_enter_in,
	input wire ch2_strike_fail_in,
	input wire ch2_overvoltage_in,
	input wire ch2_lamp_out_in,
	input wire ch2_overcurrent_in,
	// Lamp timing
	input wire lamp_tick_in,
	// Supply and power-down
	input wire supply_low_monitor_in,
	input wire supply_high_monitor_in,
	input wire uvlo_in,
	input wire power_down_pin_in,
	input wire power_down_bit_wr_in,
	// Brightness and channel control
	output reg [4:0] lamp_current_out,
	output reg first_channel_off_out,
	output reg second_channel_off_out,
	output reg nv_write_block_out,
	// Nonvolatile write port
	output reg nv_wr_out,
	output reg [7:0] nv_addr_out,
	output reg [7:0] nv_data_out,
	// Soft-start duty
	input wire ss_step_in,
	input wire [2:0] ss_pair_in,
	output reg [4:0] ss_duty_out,
	output reg [2:0] ss_code_out,
	// Strike and lamp-out timeout
	output reg [16:0] strike_timeout_out
);

// ****************************************
// Storage
// ****************************************
reg [7:0] bright_q;
reg [7:0] bright_d;
reg [7:0] ss_q [0:3];
reg [7:0] ss_d [0:3];
reg [1:0] supply_prev_q;
reg [7:0] rdata_d;
reg nv_wr_d;
reg [4:0] duty_d;
reg [2:0] code_d;
reg [16:0] tmo_d;
reg [2:0] sel_code;
reg [7:0] sel_reg;
reg supply_cross;
reg common_clear;
reg ss_hit;
reg [1:0] ss_idx;
integer i;
integer k;

wire [5:0] ch1_flags;
wire [5:0] ch2_flags;
wire ch1_clear;
wire ch2_clear;
wire rd_ch1;
wire rd_ch2;
wire [1:0] strike_sel;

// ****************************************
// Clear conditions
// ****************************************
// Any change of either comparator level between cycles counts as a crossing
always @* begin
	supply_cross = (supply_prev_q != {supply_high_monitor_in, supply_low_monitor_in});
	common_clear = uvlo_in || supply_cross || power_down_pin_in || power_down_bit_wr_in;
end

assign ch1_clear = common_clear || bright_q[`LSBR_BR_CH1_OFF]; // RQ10
assign ch2_clear = common_clear || bright_q[`LSBR_BR_CH2_OFF]; // RQ11
assign rd_ch1 = reg_rd_in && (reg_addr_in == `LSBR_ADDR_CH1_STATUS); // RQ3
assign rd_ch2 = reg_rd_in && (reg_addr_in == `LSBR_ADDR_CH2_STATUS); // RQ3

// ****************************************
// Channel status flags
// ****************************************
lsbr_chan_status #(
	.OV_CNT_W(7)
) u_ch1_status (
	.ref_clk_in(ref_clk_in),
	.srst_in(srst_in),
	.clear_in(ch1_clear),
	.read_clear_in(rd_ch1),
	.fault_now_in(ch1_fault_now_in),
	.fault_enter_in(ch1_fault_enter_in),
	.strike_fail_in(ch1_strike_fail_in),
	.overvoltage_in(ch1_overvoltage_in),
	.lamp_tick_in(lamp_tick_in),
	.lamp_out_in(ch1_lamp_out_in),
	.overcurrent_in(ch1_overcurrent_in),
	.flags_out(ch1_flags)
);

lsbr_chan_status #(
	.OV_CNT_W(7)
) u_ch2_status (
	.ref_clk_in(ref_clk_in),
	.srst_in(srst_in),
	.clear_in(ch2_clear),
	.read_clear_in(rd_ch2),
	.fault_now_in(ch2_fault_now_in),
	.fault_enter_in(ch2_fault_enter_in),
	.strike_fail_in(ch2_strike_fail_in),
	.overvoltage_in(ch2_overvoltage_in),
	.lamp_tick_in(lamp_tick_in),
	.lamp_out_in(ch2_lamp_out_in),
	.overcurrent_in(ch2_overcurrent_in),
	.flags_out(ch2_flags)
);

// ****************************************
// Register writes
// ****************************************
always @* begin
	bright_d = bright_q;
	for (i = 0; i < 4; i = i + 1) begin
		ss_d[i] = ss_q[i];
	end
	ss_hit = 1'b0;
	ss_idx = reg_addr_in[1:0];
	nv_wr_d = 1'b0;
	if (reg_wr_in) begin
		case (reg_addr_in)
			`LSBR_ADDR_BRIGHTNESS: begin
				bright_d = reg_wdata_in; // RQ13 RQ14 RQ15
			end
			`LSBR_ADDR_SS_1_4, `LSBR_ADDR_SS_5_8,
			`LSBR_ADDR_SS_9_12, `LSBR_ADDR_SS_13_16: begin
				ss_hit = 1'b1;
			end
			default: begin
				// Status writes and unmapped addresses change nothing
				bright_d = bright_q; // RQ9
			end
		endcase
	end
	if (ss_hit) begin
		ss_d[ss_idx] = reg_wdata_in; // RQ17
		nv_wr_d = !bright_q[`LSBR_BR_NV_BLOCK]; // RQ16
	end
end

// ****************************************
// Status bytes
// ****************************************
wire [7:0] status1_byte;
wire [7:0] status2_byte;

assign status1_byte = {supply_high_monitor_in, supply_low_monitor_in, ch1_flags}; // RQ8
// Reserved bits of the second status byte read as zero
assign status2_byte = {2'b00, ch2_flags}; // RQ12

// ****************************************
// Read data
// ****************************************
always @* begin
	rdata_d = 8'h00;
	case (reg_addr_in)
		`LSBR_ADDR_CH1_STATUS: begin
			rdata_d = status1_byte; // RQ8
		end
		`LSBR_ADDR_CH2_STATUS: begin
			rdata_d = status2_byte; // RQ12
		end
		`LSBR_ADDR_BRIGHTNESS: begin
			rdata_d = bright_q;
		end
		`LSBR_ADDR_SS_1_4, `LSBR_ADDR_SS_5_8,
		`LSBR_ADDR_SS_9_12, `LSBR_ADDR_SS_13_16: begin
			rdata_d = ss_q[reg_addr_in[1:0]];
		end
		default: begin
			rdata_d = 8'h00;
		end
	endcase
end

// ****************************************
// Soft-start duty selection
// ****************************************
always @* begin
	sel_reg = ss_q[ss_pair_in[2:1]]; // RQ17
	if (ss_pair_in[0]) begin
		sel_code = sel_reg[`LSBR_SS_HI_MSB:`LSBR_SS_HI_LSB];
	end else begin
		sel_code = sel_reg[`LSBR_SS_LO_MSB:0];
	end
	duty_d = ss_duty_out;
	code_d = ss_code_out;
	if (ss_step_in) begin
		code_d = sel_code;
		case (sel_code)
			3'h0: duty_d = `LSBR_DUTY_0; // RQ19
			3'h1: duty_d = `LSBR_DUTY_1;
			3'h2: duty_d = `LSBR_DUTY_2;
			3'h3: duty_d = `LSBR_DUTY_3;
			3'h4: duty_d = `LSBR_DUTY_4;
			3'h5: duty_d = `LSBR_DUTY_5;
			3'h6: duty_d = `LSBR_DUTY_6;
			default: duty_d = ss_duty_out; // RQ19
		endcase
	end
end

// ****************************************
// Strike timeout decode
// ****************************************
assign strike_sel = {ss_q[0][`LSBR_SS_TMO_HI], ss_q[0][`LSBR_SS_TMO_LO]};

always @* begin
	case (strike_sel)
		2'b00: tmo_d = `LSBR_TMO_CODE_0; // RQ18
		2'b01: tmo_d = `LSBR_TMO_CODE_1; // RQ18
		2'b10: tmo_d = `LSBR_TMO_CODE_2; // RQ18
		default: tmo_d = `LSBR_TMO_CODE_0;
	endcase
end

// ****************************************
// Brightness register
// ****************************************
always @(posedge ref_clk_in) begin
	if (srst_in) begin
		bright_q <= `LSBR_RST_BRIGHTNESS;
	end else begin
		bright_q <= bright_d;
	end
end

// ****************************************
// Soft-start registers
// ****************************************
always @(posedge ref_clk_in) begin
	if (srst_in) begin
		ss_q[0] <= `LSBR_RST_SS_1_4;
		ss_q[1] <= `LSBR_RST_SS_5_8;
		ss_q[2] <= `LSBR_RST_SS_9_12;
		ss_q[3] <= `LSBR_RST_SS_13_16;
	end else begin
		for (k = 0; k < 4; k = k + 1) begin
			ss_q[k] <= ss_d[k];
		end
	end
end

// ****************************************
// Supply monitor history
// ****************************************
always @(posedge ref_clk_in) begin
	if (srst_in) begin
		supply_prev_q <= 2'b00;
	end else begin
		supply_prev_q <= {supply_high_monitor_in, supply_low_monitor_in};
	end
end

// ****************************************
// Read port
// ****************************************
// Read data holds between reads so the serial engine may fetch it late
always @(posedge ref_clk_in) begin
	if (srst_in) begin
		reg_rdata_out <= `LSBR_RST_STATUS;
		reg_rvalid_out <= 1'b0;
	end else begin
		reg_rvalid_out <= reg_rd_in;
		if (reg_rd_in) begin
			reg_rdata_out <= rdata_d;
		end
	end
end

// ****************************************
// Nonvolatile write port
// ****************************************
// Address and data hold after the pulse for the memory side
always @(posedge ref_clk_in) begin
	if (srst_in) begin
		nv_wr_out <= 1'b0;
		nv_addr_out <= 8'h00;
		nv_data_out <= 8'h00;
	end else begin
		nv_wr_out <= nv_wr_d; // RQ16
		if (nv_wr_d) begin
			nv_addr_out <= reg_addr_in;
			nv_data_out <= reg_wdata_in;
		end
	end
end

// ****************************************
// Soft-start and timeout outputs
// ****************************************
always @(posedge ref_clk_in) begin
	if (srst_in) begin
		ss_duty_out <= `LSBR_DUTY_0;
		ss_code_out <= 3'h0;
		strike_timeout_out <= `LSBR_TMO_CODE_0;
	end else begin
		ss_duty_out <= duty_d;
		ss_code_out <= code_d;
		strike_timeout_out <= tmo_d;
	end
end

// ****************************************
// Brightness outputs
// ****************************************
always @(posedge ref_clk_in) begin
	if (srst_in) begin
		lamp_current_out <= 5'h00;
		first_channel_off_out <= 1'b0;
		second_channel_off_out <= 1'b0;
		nv_write_block_out <= 1'b0;
	end else begin
		lamp_current_out <= bright_q[`LSBR_BR_CUR_MSB:0]; // RQ13
		first_channel_off_out <= bright_q[`LSBR_BR_CH1_OFF]; // RQ14
		second_channel_off_out <= bright_q[`LSBR_BR_CH2_OFF]; // RQ15
		nv_write_block_out <= bright_q[`LSBR_BR_NV_BLOCK]; // RQ16
	end
end

endmodule // lsbr_top

//--- lsbr_assertions.sv
// Assertion checker for the lamp status and settings register bank
`timescale 1ns/1ps
module lsbr_checker (
	// Clock and reset
	input wire ref_clk_in,
	input wire srst_in,
	// Register port
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_rdata_out,
	// Status sources and settings
	input wire ch1_fault_now_in,
	input wire ch2_fault_now_in,
	input wire ch1_lamp_out_in,
	input wire supply_low_monitor_in,
	input wire supply_high_monitor_in,
	input wire uvlo_in,
	input wire power_down_pin_in,
	input wire power_down_bit_wr_in,
	input wire [4:0] lamp_current_out,
	input wire first_channel_off_out,
	input wire second_channel_off_out,
	input wire nv_write_block_out,
	input wire nv_wr_out,
	input wire [7:0] nv_data_out
);
	// ****************
	// Checks
	// ****************
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);
	wire rd1 = reg_rd_in && reg_addr_in == 8'hE0;
	wire rd2 = reg_rd_in && reg_addr_in == 8'hE1;
	wire wrb = reg_wr_in && reg_addr_in == 8'hE3;
	wire wrf = reg_wr_in && reg_addr_in[7:2] == 6'h3C;
	wire hw_quiet = !uvlo_in && !power_down_pin_in && !power_down_bit_wr_in;
	wire [1:0] mon = {supply_high_monitor_in, supply_low_monitor_in};
	chk_ch1_live:
	assert property (rd1 |=> reg_rdata_out[0] == $past(ch1_fault_now_in)) else $error("ch1 live");
	chk_ch2_live:
	assert property (rd2 |=> reg_rdata_out[0] == $past(ch2_fault_now_in)) else $error("ch2 live");
	chk_monitor_live:
	assert property (rd1 |=> reg_rdata_out[7:6] == {$past(supply_high_monitor_in),
		$past(supply_low_monitor_in)}) else $error("monitor bits");
	chk_bright_fields:
	assert property (wrb ##1 !reg_wr_in |=> {nv_write_block_out, second_channel_off_out,
		first_channel_off_out, lamp_current_out} == $past(reg_wdata_in, 2)) else $error("fields");
	chk_nv_blocked:
	assert property (wrf && nv_write_block_out && !$past(reg_wr_in) |=> !nv_wr_out)
		else $error("nv not blocked");
	chk_nv_passes:
	assert property (wrf && !nv_write_block_out && !$past(reg_wr_in) |=>
		nv_wr_out && nv_data_out == $past(reg_wdata_in)) else $error("nv missing");
	chk_hw_clear:
	assert property (($past(uvlo_in) || $past(power_down_pin_in)) && (rd1 || rd2) |=>
		reg_rdata_out[5:1] == 5'h00) else $error("not cleared");
	chk_event_kept:
	assert property (rd1 && ch1_lamp_out_in && hw_quiet && $stable(mon) ##1
		!rd1 && hw_quiet && $stable(mon) && !first_channel_off_out ##1
		rd1 && !first_channel_off_out |=> reg_rdata_out[4]) else $error("event lost");
	cover property (rd1 ##1 reg_rdata_out[3]);
	cover property (wrf ##1 nv_wr_out);
	cover property (wrb);
endmodule // lsbr_checker

bind lsbr_top lsbr_checker u_chk (.*);

//--- lsbr_host.sv
// Host model driving the register byte port
`timescale 1ns/1ps
module lsbr_host (
	// Clock
	input wire ref_clk_in,
	// Register port
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out,
	output logic reg_wr_out,
	output logic reg_rd_out,
	input wire [7:0] reg_rdata_in,
	input wire reg_rvalid_in
);
	// ****************
	// Byte transfers, entered at a clock edge
	// ****************
	initial begin
		{reg_addr_out, reg_wdata_out, reg_wr_out, reg_rd_out} = 18'h00000;
	end
	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_out <= a;
		reg_wdata_out <= d;
		reg_wr_out <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_out <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr_out <= a;
		reg_rd_out <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_out <= 1'b0;
		@(posedge ref_clk_in);
		d = reg_rvalid_in ? reg_rdata_in : 8'hXX;
	endtask
endmodule // lsbr_host

//--- tb.sv
// Self-checking testbench for the lamp register bank
`timescale 1ns/1ps
module tb;
	// ****************
	// Signals and instances
	// ****************
	logic ref_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [5:0] ev1 = 6'h00;
	logic [5:0] ev2 = 6'h00;
	logic lamp_tick_in = 1'b0;
	logic supply_low_monitor_in = 1'b0;
	logic supply_high_monitor_in = 1'b0;
	logic uvlo_in = 1'b0;
	logic power_down_pin_in = 1'b0;
	logic power_down_bit_wr_in = 1'b0;
	logic ss_step_in = 1'b0;
	logic [2:0] ss_pair_in = 3'h0;
	wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, nv_addr_out, nv_data_out;
	wire reg_wr_in, reg_rd_in, reg_rvalid_out, nv_write_block_out, nv_wr_out;
	wire first_channel_off_out, second_channel_off_out;
	wire [4:0] lamp_current_out, ss_duty_out;
	wire [2:0] ss_code_out;
	wire [16:0] strike_timeout_out;
	int num_errors = 0;
	int comparisons = 0;
	int nv_cnt = 0;
	logic [7:0] d;
	logic [7:0] ra [8] = '{8'hE0, 8'hE1, 8'hE3, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hE2};
	logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h21, 8'h43, 8'h65, 8'h77, 8'h00};
	logic [4:0] dt [7] = '{5'h00, 5'h03, 5'h06, 5'h09, 5'h0D, 5'h10, 5'h13};
	logic [16:0] tmo [4] = '{17'h08000, 17'h10000, 17'h18000, 17'h08000};
	lsbr_top uut (.*, .ch1_fault_now_in(ev1[0]), .ch1_fault_enter_in(ev1[1]),
		.ch1_strike_fail_in(ev1[2]), .ch1_overvoltage_in(ev1[3]), .ch1_lamp_out_in(ev1[4]),
		.ch1_overcurrent_in(ev1[5]), .ch2_fault_now_in(ev2[0]), .ch2_fault_enter_in(ev2[1]),
		.ch2_strike_fail_in(ev2[2]), .ch2_overvoltage_in(ev2[3]), .ch2_lamp_out_in(ev2[4]),
		.ch2_overcurrent_in(ev2[5]));
	lsbr_host h (.ref_clk_in(ref_clk_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
		.reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_rdata_in(reg_rdata_out),
		.reg_rvalid_in(reg_rvalid_out));
	always #12.5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in) if (nv_wr_out === 1'b1) nv_cnt <= nv_cnt + 1;
	// ****************
	// Helpers
	// ****************
	task tk;
		@(posedge ref_clk_in);
	endtask
	task cmp(input logic [16:0] got, input logic [16:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rchk(input logic [7:0] a, input logic [7:0] e);
		h.rd(a, d);
		cmp(17'(d), 17'(e));
	endtask
	task tick;
		lamp_tick_in <= 1'b1;
		tk;
		lamp_tick_in <= 1'b0;
		tk;
	endtask
	task blip;
		{ev1[4], ev2[4]} <= 2'b11;
		tk;
		{ev1[4], ev2[4]} <= 2'b00;
	endtask
	task print_verdict;
		$display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_regs;
		for (int k = 0; k < 8; k++) rchk(ra[k], rv[k]);
		$display("regs done");
	endtask
	task t_latch;
		for (int k = 1; k < 6; k++) begin
			if (k != 3) begin
				ev1 <= 6'h01 | (6'h01 << k);
				ev2[k] <= 1'b1;
				tk;
				ev1[k] <= 1'b0;
				ev2[k] <= 1'b0;
				rchk(8'hE0, 8'h01 | (8'h01 << k));
				rchk(8'hE1, 8'h01 << k);
				rchk(8'hE0, 8'h01);
			end
		end
		ev1 <= 6'h00;
		ev2[0] <= 1'b1;
		tk;
		rchk(8'hE1, 8'h01);
		ev2[0] <= 1'b0;
		$display("latch done");
	endtask
	task t_ov;
		{ev1[3], ev2[3]} <= 2'b11;
		tk;
		repeat (63) tick;
		rchk(8'hE0, 8'h00);
		tick;
		rchk(8'hE0, 8'h08);
		rchk(8'hE1, 8'h08);
		{ev1[3], ev2[3]} <= 2'b00;
		$display("ov done");
	endtask
	task t_clear;
		for (int k = 0; k < 4; k++) begin
			blip;
			case (k)
				0: uvlo_in <= 1'b1;
				1: power_down_pin_in <= 1'b1;
				2: power_down_bit_wr_in <= 1'b1;
				default: {supply_high_monitor_in, supply_low_monitor_in} <= 2'b11;
			endcase
			tk;
			{uvlo_in, power_down_pin_in, power_down_bit_wr_in} <= 3'h0;
			rchk(8'hE0, k == 3 ? 8'hC0 : 8'h00);
			rchk(8'hE1, 8'h00);
		end
		{supply_high_monitor_in, supply_low_monitor_in} <= 2'b00;
		h.wr(8'hE3, 8'h20);
		blip;
		rchk(8'hE0, 8'h00);
		rchk(8'hE1, 8'h10);
		h.wr(8'hE3, 8'h40);
		blip;
		rchk(8'hE0, 8'h10);
		rchk(8'hE1, 8'h00);
		h.wr(8'hE3, 8'h00);
		$display("clear done");
	endtask
	task t_status_wr;
		blip;
		h.wr(8'hE0, 8'hFF);
		h.wr(8'hE1, 8'h00);
		rchk(8'hE0, 8'h10);
		rchk(8'hE1, 8'h10);
		ev1[4] <= 1'b1;
		fork
			h.rd(8'hE0, d);
			begin
				tk;
				ev1[4] <= 1'b0;
			end
		join
		rchk(8'hE0, 8'h10);
		$display("status write done");
	endtask
	task t_settings;
		for (int k = 0; k < 3; k++) begin
			h.wr(8'hE3, k == 0 ? 8'hA5 : k == 1 ? 8'h5A : 8'h1F);
			#1;
			cmp(17'({nv_write_block_out, second_channel_off_out, first_channel_off_out,
				lamp_current_out}), k == 0 ? 17'h000A5 : k == 1 ? 17'h0005A : 17'h0001F);
			tk;
		end
		h.wr(8'hE3, 8'h00);
		h.wr(8'hF1, 8'h5C);
		tk;
		cmp(17'(nv_cnt), 17'h00001);
		cmp(17'({nv_addr_out, nv_data_out}), 17'h0F15C);
		h.wr(8'hE3, 8'h80);
		tk;
		h.wr(8'hF2, 8'h11);
		tk;
		cmp(17'(nv_cnt), 17'h00001);
		rchk(8'hF2, 8'h11);
		h.wr(8'hE3, 8'h00);
		$display("settings done");
	endtask
	task t_ss;
		for (int p = 0; p < 8; p++) begin
			h.wr(8'hF0 + 8'(p / 2), (p % 2) != 0 ? 8'(p << 4) : 8'(p));
			ss_pair_in <= 3'(p);
			ss_step_in <= 1'b1;
			tk;
			ss_step_in <= 1'b0;
			#1;
			cmp(17'(ss_code_out), 17'(p));
			cmp(17'(ss_duty_out), 17'(dt[p < 7 ? p : 6]));
			tk;
		end
		for (int k = 0; k < 4; k++) begin
			h.wr(8'hF0, {k[1], 3'h0, k[0], 3'h0});
			#1;
			cmp(strike_timeout_out, tmo[k]);
			tk;
		end
		$display("soft-start done");
	endtask
	// ****************
	// Sequence and watchdog
	// ****************
	initial begin
		repeat (4) tk;
		srst_in <= 1'b0;
		t_regs;
		t_latch;
		t_ov;
		t_clear;
		t_status_wr;
		t_settings;
		t_ss;
		print_verdict;
	end
	// About 300 cycles expected; allow over twenty-five times that
	initial begin
		#200000;
		num_errors = num_errors + 1;
		print_verdict;
	end
endmodule // tb
